// File: core/pscl_pkg.sv
// constants for the strap configuration loader
package pscl_pkg;
   localparam int ADDR_W = 5;
   localparam int STRAP_ADDR_W = 3;
   localparam logic [2:0] ADDR_RESET = 3'h0;
   // operating mode strap encodings
   localparam logic [2:0] MODE_10_HD = 3'h0;
   localparam logic [2:0] MODE_10_FD = 3'h1;
   localparam logic [2:0] MODE_100_HD = 3'h2;
   localparam logic [2:0] MODE_100_FD = 3'h3;
   localparam logic [2:0] MODE_AN_100HD = 3'h4;
   localparam logic [2:0] MODE_REPEATER = 3'h5;
   localparam logic [2:0] MODE_POWER_DOWN = 3'h6;
   localparam logic [2:0] MODE_ALL = 3'h7;
   localparam logic [2:0] MODE_RESET = 3'h7;
   // control bits {speed13, an_en12, pd11, duplex8}
   localparam logic [3:0] CTRL_10_HD = 4'h0;
   localparam logic [3:0] CTRL_10_FD = 4'h1;
   localparam logic [3:0] CTRL_100_HD = 4'h8;
   localparam logic [3:0] CTRL_100_FD = 4'h9;
   localparam logic [3:0] CTRL_AN = 4'hc;
   // advertisement bits 8,7,6,5
   localparam logic [3:0] ADV_100HD = 4'h4;
   localparam logic [3:0] ADV_ALL = 4'hf;
   localparam logic [3:0] ADV_RESET = 4'hf;
   localparam logic [3:0] CTRL_RESET = 4'hc;
   // frame field positions in the address comparator
   localparam int FRAME_ADDR_LSB = 0;
endpackage

// File: core/pscl_addr_match.sv
// management frame address comparator
`timescale 1ns/1ps
module pscl_addr_match #(
   parameter int W = 5
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] frame_addr,
   input wire logic frame_valid,
   input wire logic [W-1:0] station_addr,
   output logic hit
);
   logic hit_reg;
   logic hit_next;
   always_comb begin
      hit_next = frame_valid && (frame_addr == station_addr); // R2 R20
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         hit_reg <= 1'b0;
      end else begin
         hit_reg <= hit_next;
      end
   end
   assign hit = hit_reg;
endmodule

// File: core/pscl_mode_decode.sv
// operating mode strap decoder
`timescale 1ns/1ps
module pscl_mode_decode (
   input wire logic [2:0] mode,
   output logic [3:0] ctrl_bits,
   output logic [3:0] adv_bits,
   output logic adv_valid,
   output logic power_down,
   output logic repeater,
   output logic crs_rx_only
);
   always_comb begin
      ctrl_bits = pscl_pkg::CTRL_10_HD;
      adv_bits = pscl_pkg::ADV_ALL;
      adv_valid = 1'b0;
      power_down = 1'b0;
      repeater = 1'b0;
      crs_rx_only = 1'b0;
      case (mode)
         pscl_pkg::MODE_10_HD: ctrl_bits = pscl_pkg::CTRL_10_HD; // R9
         pscl_pkg::MODE_10_FD: ctrl_bits = pscl_pkg::CTRL_10_FD; // R9
         pscl_pkg::MODE_100_HD: ctrl_bits = pscl_pkg::CTRL_100_HD; // R10
         pscl_pkg::MODE_100_FD: begin
            ctrl_bits = pscl_pkg::CTRL_100_FD; // R10
            crs_rx_only = 1'b1;
         end
         pscl_pkg::MODE_AN_100HD: begin
            ctrl_bits = pscl_pkg::CTRL_AN; // R11
            adv_bits = pscl_pkg::ADV_100HD;
            adv_valid = 1'b1;
         end
         pscl_pkg::MODE_REPEATER: begin
            ctrl_bits = pscl_pkg::CTRL_AN; // R12
            adv_bits = pscl_pkg::ADV_100HD;
            adv_valid = 1'b1;
            repeater = 1'b1;
            crs_rx_only = 1'b1;
         end
         pscl_pkg::MODE_POWER_DOWN: power_down = 1'b1; // R14
         default: begin
            ctrl_bits = pscl_pkg::CTRL_AN; // R13
            adv_bits = pscl_pkg::ADV_ALL;
            adv_valid = 1'b1;
         end
      endcase
   end
endmodule

// File: core/pscl_loader.sv
// strap capture, register defaults and address match for the transceiver
// Notes on behaviour
// R1: address straps captured when hardware reset ends; default zero.
// R2: management frames answered only when their address equals ours.
// R3: stored address also seeds the transmit scrambler.
// R4: strap addresses span zero to seven; higher needs software write.
// R5: controller may rewrite address field after talking at current address.
// R6: address bits from rx error, rx clock and rx data 3 pins.
// R7: reset pin release loads control/advert bits from mode straps.
// R8: soft reset keeps register contents and ignores mode straps.
// R9: modes 000/001 give control 0000/0001, 10 Mb, no negotiation.
// R10: modes 010/011 give control 1000/1001, 100 Mb, no negotiation.
// R11: mode 100 gives control 1100, advertisement 0100.
// R12: mode 101 is repeater, same defaults, carrier sense receive only.
// R13: mode 111 gives control X10X, advertisement 1111.
// R14: mode 110 wakes powered down; exit by new mode and soft reset.
// R15: interface select latched at reset release, high picks reduced.
// R16: interface kind bit loaded from strap and shows active mode.
// R17: controller may rewrite operating mode registers any time.
// R18: straps sampled only at power-on and external reset.
// R19: soft-reset-surviving bits kept on soft reset; hard reset clears all.
// R20: compare all five address bits; strap value zero-extended.
// R21: shared pins return to receive outputs; no resampling until reset.
`timescale 1ns/1ps
module pscl_loader #(
   parameter int ADDR_W = pscl_pkg::ADDR_W
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic external_reset_n,
   input wire logic rx_error_shared_pin,
   input wire logic rx_clock_shared_pin,
   input wire logic rx_data3_shared_pin,
   input wire logic rx_data0_shared_pin,
   input wire logic rx_data1_shared_pin,
   input wire logic collision_shared_pin,
   input wire logic reduced_interface_select_strap,
   input wire logic soft_reset,
   input wire logic addr_wr,
   input wire logic [ADDR_W-1:0] addr_wr_data,
   input wire logic mode_wr,
   input wire logic [2:0] mode_wr_data,
   input wire logic ctrl_wr,
   input wire logic [3:0] ctrl_wr_data,
   input wire logic adv_wr,
   input wire logic [3:0] adv_wr_data,
   input wire logic frame_valid,
   input wire logic [ADDR_W-1:0] frame_addr,
   output logic frame_hit,
   output logic [ADDR_W-1:0] station_address_field,
   output logic [ADDR_W-1:0] scrambler_seed,
   output logic [2:0] mode_field,
   output logic [3:0] ctrl_bits,
   output logic [3:0] adv_bits,
   output logic power_down,
   output logic repeater,
   output logic crs_rx_only,
   output logic interface_kind_bit,
   output logic straps_sampling
);
   logic [ADDR_W-1:0] addr_reg;
   logic [ADDR_W-1:0] addr_next;
   logic [2:0] mode_reg;
   logic [2:0] mode_next;
   logic [3:0] ctrl_reg;
   logic [3:0] ctrl_next;
   logic [3:0] adv_reg;
   logic [3:0] adv_next;
   logic pd_reg;
   logic pd_next;
   logic rep_reg;
   logic rep_next;
   logic crs_reg;
   logic crs_next;
   logic kind_reg;
   logic kind_next;
   logic rst_pin_reg;
   logic rst_pin_next;
   logic in_reset;
   logic release_evt;
   logic [2:0] strap_mode;
   logic [3:0] dec_ctrl;
   logic [3:0] dec_adv;
   logic dec_adv_valid;
   logic dec_pd;
   logic dec_rep;
   logic dec_crs;
   logic [2:0] soft_mode;
   logic [3:0] sdec_ctrl;
   logic [3:0] sdec_adv;
   logic sdec_adv_valid;
   logic sdec_pd;
   logic sdec_rep;
   logic sdec_crs;

   // power-on reset and the external pin both hold the straps open
   assign in_reset = !external_reset_n;
   assign release_evt = rst_pin_reg && external_reset_n; // R18
   assign strap_mode = {collision_shared_pin, rx_data1_shared_pin,
      rx_data0_shared_pin};

   pscl_mode_decode u_strap_dec (
      .mode(strap_mode),
      .ctrl_bits(dec_ctrl),
      .adv_bits(dec_adv),
      .adv_valid(dec_adv_valid),
      .power_down(dec_pd),
      .repeater(dec_rep),
      .crs_rx_only(dec_crs)
   );

   assign soft_mode = mode_wr ? mode_wr_data : mode_reg;

   pscl_mode_decode u_soft_dec (
      .mode(soft_mode),
      .ctrl_bits(sdec_ctrl),
      .adv_bits(sdec_adv),
      .adv_valid(sdec_adv_valid),
      .power_down(sdec_pd),
      .repeater(sdec_rep),
      .crs_rx_only(sdec_crs)
   );

   always_comb begin
      addr_next = addr_reg;
      mode_next = mode_reg;
      ctrl_next = ctrl_reg;
      adv_next = adv_reg;
      pd_next = pd_reg;
      rep_next = rep_reg;
      crs_next = crs_reg;
      kind_next = kind_reg;
      rst_pin_next = in_reset;
      if (release_evt) begin
         addr_next = {{(ADDR_W-3){1'b0}}, rx_data3_shared_pin,
            rx_clock_shared_pin, rx_error_shared_pin}; // R1 R4 R6 R20
         mode_next = strap_mode; // R7
         ctrl_next = dec_ctrl; // R9 R10 R11 R13
         if (dec_adv_valid) begin
            adv_next = dec_adv; // R11 R12 R13
         end else begin
            adv_next = pscl_pkg::ADV_RESET; // R19
         end
         pd_next = dec_pd; // R14
         rep_next = dec_rep; // R12
         crs_next = dec_crs;
         kind_next = reduced_interface_select_strap; // R15 R16
      end else if (!in_reset) begin
         // between resets the straps are never looked at
         if (addr_wr) begin
            addr_next = addr_wr_data; // R5
         end
         if (mode_wr) begin
            mode_next = mode_wr_data; // R14
         end
         if (ctrl_wr) begin
            ctrl_next = ctrl_wr_data; // R17
         end
         if (adv_wr) begin
            adv_next = adv_wr_data; // R17
         end
         if (soft_reset) begin
            // address, mode and interface kind survive; straps ignored
            pd_next = sdec_pd; // R8 R14 R19
            rep_next = sdec_rep; // R8
            crs_next = sdec_crs; // R8
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         addr_reg <= {{(ADDR_W-pscl_pkg::STRAP_ADDR_W){1'b0}},
            pscl_pkg::ADDR_RESET}; // R19
         mode_reg <= pscl_pkg::MODE_RESET;
         ctrl_reg <= pscl_pkg::CTRL_RESET;
         adv_reg <= pscl_pkg::ADV_RESET;
         pd_reg <= 1'b0;
         rep_reg <= 1'b0;
         crs_reg <= 1'b0;
         kind_reg <= 1'b0;
         rst_pin_reg <= 1'b1;
      end else begin
         addr_reg <= addr_next;
         mode_reg <= mode_next;
         ctrl_reg <= ctrl_next;
         adv_reg <= adv_next;
         pd_reg <= pd_next;
         rep_reg <= rep_next;
         crs_reg <= crs_next;
         kind_reg <= kind_next;
         rst_pin_reg <= rst_pin_next;
      end
   end

   pscl_addr_match #(.W(ADDR_W)) u_match (
      .clk(clk),
      .reset(reset),
      .frame_addr(frame_addr),
      .frame_valid(frame_valid),
      .station_addr(addr_reg),
      .hit(frame_hit)
   );

   assign station_address_field = addr_reg;
   assign scrambler_seed = addr_reg; // R3
   assign mode_field = mode_reg;
   assign ctrl_bits = ctrl_reg;
   assign adv_bits = adv_reg;
   assign power_down = pd_reg;
   assign repeater = rep_reg;
   assign crs_rx_only = crs_reg;
   assign interface_kind_bit = kind_reg;
   // shared pins carry straps only while reset is held
   assign straps_sampling = rst_pin_reg; // R21

   sequence s_release;
      rst_pin_reg && external_reset_n;
   endsequence

   AST_ADDR_LOAD: assert property (@(posedge clk) disable iff (reset)
      s_release |=> station_address_field ==
      {2'b00, $past(rx_data3_shared_pin), $past(rx_clock_shared_pin),
      $past(rx_error_shared_pin)}) // R1
      else $error("address not loaded from straps");
   AST_ADDR_RANGE: assert property (@(posedge clk) disable iff (reset)
      s_release |=> station_address_field[4:3] == 2'b00) // R4
      else $error("strap address above seven");
   AST_HIT: assert property (@(posedge clk) disable iff (reset)
      frame_valid && frame_addr == addr_reg |=> frame_hit) // R2
      else $error("matching frame not answered");
   AST_NO_HIT: assert property (@(posedge clk) disable iff (reset)
      frame_valid && frame_addr != addr_reg |=> !frame_hit) // R20
      else $error("mismatched frame answered");
   AST_SEED: assert property (@(posedge clk) disable iff (reset)
      scrambler_seed == station_address_field) // R3
      else $error("seed differs from address");
   AST_MODE_LOAD: assert property (@(posedge clk) disable iff (reset)
      (s_release and strap_mode == pscl_pkg::MODE_100_FD) |=>
      ctrl_bits == pscl_pkg::CTRL_100_FD && crs_rx_only) // R10
      else $error("mode 011 defaults wrong");
   AST_PD_LOAD: assert property (@(posedge clk) disable iff (reset)
      (s_release and strap_mode == pscl_pkg::MODE_POWER_DOWN) |=>
      power_down) // R14
      else $error("power down mode not entered");
   AST_SOFT_KEEP: assert property (@(posedge clk) disable iff (reset)
      soft_reset && external_reset_n && !rst_pin_reg && !addr_wr |=>
      $stable(station_address_field) && $stable(interface_kind_bit)) // R8
      else $error("soft reset disturbed kept bits");
   AST_KIND: assert property (@(posedge clk) disable iff (reset)
      s_release |=> interface_kind_bit ==
      $past(reduced_interface_select_strap)) // R15
      else $error("interface kind not latched");
   AST_NO_RESAMPLE: assert property (@(posedge clk) disable iff (reset)
      !rst_pin_reg && external_reset_n && !mode_wr ##1 !soft_reset
      |-> $stable(mode_field)) // R21
      else $error("mode resampled outside reset");

   // soft reset taken while the pin is released
   sequence s_soft;
      soft_reset && external_reset_n && !rst_pin_reg;
   endsequence

   AST_MODE_10HD: assert property (@(posedge clk) disable iff (reset)
      (s_release and strap_mode == pscl_pkg::MODE_10_HD) |=>
      ctrl_bits == pscl_pkg::CTRL_10_HD && !power_down) // R9
      else $error("mode 000 defaults wrong");
   AST_MODE_10FD: assert property (@(posedge clk) disable iff (reset)
      (s_release and strap_mode == pscl_pkg::MODE_10_FD) |=>
      ctrl_bits == pscl_pkg::CTRL_10_FD) // R9
      else $error("mode 001 defaults wrong");
   AST_MODE_100HD: assert property (@(posedge clk) disable iff (reset)
      (s_release and strap_mode == pscl_pkg::MODE_100_HD) |=>
      ctrl_bits == pscl_pkg::CTRL_100_HD && !crs_rx_only) // R10
      else $error("mode 010 defaults wrong");
   AST_MODE_AN: assert property (@(posedge clk) disable iff (reset)
      (s_release and strap_mode == pscl_pkg::MODE_AN_100HD) |=>
      ctrl_bits == pscl_pkg::CTRL_AN && adv_bits == pscl_pkg::ADV_100HD
      && !repeater) // R11
      else $error("mode 100 defaults wrong");
   AST_MODE_REP: assert property (@(posedge clk) disable iff (reset)
      (s_release and strap_mode == pscl_pkg::MODE_REPEATER) |=>
      repeater && crs_rx_only && adv_bits == pscl_pkg::ADV_100HD) // R12
      else $error("mode 101 defaults wrong");
   AST_MODE_ALL: assert property (@(posedge clk) disable iff (reset)
      (s_release and strap_mode == pscl_pkg::MODE_ALL) |=>
      ctrl_bits == pscl_pkg::CTRL_AN && adv_bits == pscl_pkg::ADV_ALL) // R13
      else $error("mode 111 defaults wrong");
   AST_ADV_RESTORE: assert property (@(posedge clk) disable iff (reset)
      (s_release and !strap_mode[2]) |=>
      adv_bits == pscl_pkg::ADV_RESET) // R19
      else $error("advertisement not restored");
   AST_MODE_FIELD: assert property (@(posedge clk) disable iff (reset)
      s_release |=> mode_field == $past(strap_mode)) // R7
      else $error("mode field not loaded from straps");
   AST_SAMPLE_END: assert property (@(posedge clk) disable iff (reset)
      s_release |=> !straps_sampling) // R21
      else $error("shared pins still sampling");
   AST_PIN_HOLD: assert property (@(posedge clk) disable iff (reset)
      !external_reset_n |=>
      $stable(station_address_field) && $stable(mode_field)) // R18
      else $error("registers moved while pin held");
   AST_SOFT_PD: assert property (@(posedge clk) disable iff (reset)
      s_soft |=> power_down ==
      ($past(soft_mode) == pscl_pkg::MODE_POWER_DOWN)) // R14
      else $error("soft reset power down wrong");
   AST_SOFT_CTRL: assert property (@(posedge clk) disable iff (reset)
      (s_soft and !ctrl_wr && !adv_wr) |=>
      $stable(ctrl_bits) && $stable(adv_bits)) // R8
      else $error("soft reset reloaded control bits");
   AST_HIT_PULSE: assert property (@(posedge clk) disable iff (reset)
      frame_hit |-> $past(frame_valid)) // R2
      else $error("hit without frame");
endmodule

// File: dv/pscl_mac_model.sv
// management controller model: register writes, soft reset, frames
`timescale 1ns/1ps
module pscl_mac_model (
   input wire logic clk,
   output logic [5:0] strobe,
   output logic [4:0] wdata
);
   // strobe: 0 address, 1 mode, 2 control, 3 advert, 4 soft reset, 5 frame
   initial begin
      strobe = 6'h00;
      wdata = 5'h0a;
   end
   // gap models a slow controller; data is inverted once released
   task automatic op(input int kind, input logic [4:0] d, input int gap);
      repeat (gap) @(negedge clk);
      @(negedge clk);
      strobe[kind] = 1'b1;
      wdata = d;
      @(negedge clk);
      strobe = 6'h00;
      wdata = ~d;
   endtask
endmodule

// File: dv/tb_top.sv
// self-checking testbench for the strap configuration loader
`timescale 1ns/1ps
module tb_top;
   logic clk, reset, ext_n, reduced, frame_hit, power_down, repeater;
   logic crs_rx_only, kind, sampling;
   logic [2:0] astrap, mstrap, mode_field;
   logic [5:0] strobe;
   logic [4:0] wdata, station, seed;
   logic [3:0] ctrl_bits, adv_bits;
   int num_errors = 0;
   int n_tests = 0;
   int m_addr, m_mode, m_ctrl, m_adv, m_kind, m_pd, m_rep, m_crs;
   int ctrl_tab[8] = '{0, 1, 8, 9, 12, 12, -1, 12};
   int adv_tab[8] = '{15, 15, 15, 15, 4, 4, 15, 15};

   pscl_mac_model mac_u (.clk(clk), .strobe(strobe), .wdata(wdata));
   pscl_loader dut_u (
      .clk(clk), .reset(reset), .external_reset_n(ext_n),
      .rx_error_shared_pin(astrap[0]), .rx_clock_shared_pin(astrap[1]),
      .rx_data3_shared_pin(astrap[2]), .rx_data0_shared_pin(mstrap[0]),
      .rx_data1_shared_pin(mstrap[1]), .collision_shared_pin(mstrap[2]),
      .reduced_interface_select_strap(reduced), .soft_reset(strobe[4]),
      .addr_wr(strobe[0]), .addr_wr_data(wdata), .mode_wr(strobe[1]),
      .mode_wr_data(wdata[2:0]), .ctrl_wr(strobe[2]),
      .ctrl_wr_data(wdata[3:0]), .adv_wr(strobe[3]),
      .adv_wr_data(wdata[3:0]), .frame_valid(strobe[5]),
      .frame_addr(wdata), .frame_hit(frame_hit),
      .station_address_field(station), .scrambler_seed(seed),
      .mode_field(mode_field), .ctrl_bits(ctrl_bits), .adv_bits(adv_bits),
      .power_down(power_down), .repeater(repeater),
      .crs_rx_only(crs_rx_only), .interface_kind_bit(kind),
      .straps_sampling(sampling));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic compare_all();
      check(station, m_addr);
      check(seed, m_addr);
      check(mode_field, m_mode);
      check(kind, m_kind);
      check(power_down, m_pd);
      check(repeater, m_rep);
      if (m_ctrl >= 0) check(ctrl_bits, m_ctrl);
      if (m_adv >= 0) check(adv_bits, m_adv);
      if (m_crs >= 0) check(crs_rx_only, m_crs);
   endtask

   task automatic set_model(input int m, input int a, input int r);
      m_addr = a % 8;
      m_mode = m;
      m_ctrl = ctrl_tab[m];
      m_adv = adv_tab[m];
      m_kind = r % 2;
      m_pd = (m == 6);
      m_rep = (m == 5);
      m_crs = (m == 3 || m == 5) ? 1 : ((m > 5) ? -1 : 0);
   endtask

   task automatic pin_reset(input int m, input int a, input int r);
      @(negedge clk);
      {mstrap, astrap, reduced} = {3'(m), 3'(a), 1'(r)};
      ext_n = 1'b0;
      repeat (3) @(negedge clk);
      check(sampling, 1'b1);
      ext_n = 1'b1;
      repeat (3) @(negedge clk);
      {mstrap, astrap, reduced} = 7'($urandom);
      set_model(m, a, r);
      @(negedge clk);
      check(sampling, 1'b0);
      compare_all();
   endtask

   task automatic frame(input logic [4:0] a);
      mac_u.op(5, a, $urandom % 3);
      check(frame_hit, a == 5'(m_addr));
      @(negedge clk);
      check(frame_hit, 1'b0);
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      #100us;
      num_errors++;
      finish_test();
   end

   initial begin
      void'($urandom(32'h2233e70c));
      reset = 1'b1;
      ext_n = 1'b0;
      {mstrap, astrap, reduced} = 7'h00;
      repeat (12) @(negedge clk);
      check(station, 5'h00);
      check(mode_field, 3'h7);
      check(ctrl_bits, 4'hc);
      check(adv_bits, 4'hf);
      reset = 1'b0;
      for (int m = 0; m < 8; m++) begin
         pin_reset(m, $urandom % 8, $urandom % 2);
         frame(5'(m_addr));
         frame(5'($urandom));
         frame({2'b01, 3'(m_addr)});
      end
      $display("test strap_modes done");
      mac_u.op(0, 5'h1b, 2);
      m_addr = 27;
      mac_u.op(2, 5'h01, 0);
      m_ctrl = 1;
      mac_u.op(3, 5'h0a, 1);
      m_adv = 10;
      compare_all();
      frame(5'h1b);
      frame(5'h03);
      {mstrap, astrap, reduced} = 7'h55;
      mac_u.op(4, 5'h00, 0);
      compare_all();
      $display("test software_writes done");
      pin_reset(6, 2, 0);
      mac_u.op(1, 5'h03, 2);
      m_mode = 3;
      compare_all();
      mac_u.op(4, 5'h00, 0);
      m_pd = 0;
      m_crs = 1;
      compare_all();
      $display("test power_down_exit done");
      // power-on reset with the pin released captures at once
      {mstrap, astrap, reduced} = 7'h5b;
      reset = 1'b1;
      repeat (2) @(negedge clk);
      check(station, 5'h00);
      check(adv_bits, 4'hf);
      check(sampling, 1'b1);
      reset = 1'b0;
      @(negedge clk);
      set_model(5, 5, 1);
      check(sampling, 1'b0);
      compare_all();
      {mstrap, astrap, reduced} = 7'($urandom);
      frame(5'h05);
      $display("test power_on_capture done");
      finish_test();
   end
endmodule
